// ### lds_pkg.sv
// Constants shared by the LED driver startup sequencer and its register slave.
// Assumes a 250 MHz reference clock; cycle counts are derived from it here.
package lds_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int NUM_CH = 6;
  // Enable-low or dim-low time that shuts the part down or clears the latch.
  localparam int EN_OFF_MS = 16;
  localparam int EN_OFF_CYC = (EN_OFF_MS * 1000000 + CLK_PERIOD_PS / 1000 - 1)
                              / (CLK_PERIOD_PS / 1000);
  // Settling wait before the LED pins are classified.
  localparam int DETECT_US = 1500;
  localparam int DETECT_CYC = (DETECT_US * 1000) / (CLK_PERIOD_PS / 1000);
  // Soft-start ramp time limit.
  localparam int SS_MS = 16;
  localparam int SS_CYC = (SS_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  // External fault deglitch, counted in switching cycles.
  localparam int EXT_FAULT_SW_CYC = 8;
  localparam int TMR_W = 23;
  // Register map, byte addresses on the Wishbone bus.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHAN = 8'h08;
  // Control register fields and reset value.
  localparam int CTRL_EXT_FAULT_EN_BIT = 0;
  localparam int CTRL_FORCE_OPEN_LOOP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // Status register field positions.
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_LATCHED_BIT = 1;
  localparam int ST_EXT_OFF_BIT = 2;
  localparam int ST_OPEN_LOOP_BIT = 3;
  localparam int ST_PHASE_LSB = 8;
  // Channel register field positions.
  localparam int CH_UNUSED_LSB = 0;
  localparam int CH_SHORT_LSB = 8;
  // Phase codes reported in the status register.
  localparam logic [2:0] PH_OFF = 3'h0;
  localparam logic [2:0] PH_WAKE = 3'h1;
  localparam logic [2:0] PH_WAIT_DIM = 3'h2;
  localparam logic [2:0] PH_DETECT = 3'h3;
  localparam logic [2:0] PH_SOFT = 3'h4;
  localparam logic [2:0] PH_RUN = 3'h5;
  localparam logic [2:0] PH_LATCHED = 3'h6;
  typedef enum {ST_OFF, ST_WAKE, ST_WAIT_DIM, ST_DETECT, ST_SOFT, ST_RUN, ST_LATCHED} lds_state_t;
endpackage : lds_pkg

// ### lds_regs_if.sv
// Carrier between the sequencer core and its Wishbone register slave.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface lds_regs_if;
  logic ext_fault_en;
  logic force_open_loop;
  logic [3:0] status_flags;
  logic [2:0] phase;
  logic [lds_pkg::NUM_CH-1:0] unused_mask;
  logic [lds_pkg::NUM_CH-1:0] short_mask;
  modport regs (output ext_fault_en, output force_open_loop,
                input status_flags, input phase, input unused_mask, input short_mask);
  modport core (input ext_fault_en, input force_open_loop,
                output status_flags, output phase, output unused_mask, output short_mask);
endinterface : lds_regs_if
`default_nettype wire

// ### lds_hold_timer.sv
// Counter that reports when a condition has held for LIMIT counted steps.
// Assumes i_run and i_inc are on the module clock; dropping i_run restarts it.
`timescale 1ns/1ps
`default_nettype none
module lds_hold_timer #(
  parameter int W = lds_pkg::TMR_W,
  parameter int LIMIT = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_run,
  input wire logic i_inc,
  output logic o_done
);
  if (LIMIT < 1 || LIMIT >= (1 << W)) begin : g_bad_limit
    $error("lds_hold_timer: LIMIT does not fit the counter width");
  end
  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);
  logic [W-1:0] cnt_ff;
  // The count saturates at the limit so a long hold cannot wrap and re-arm.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!i_run) begin
      cnt_ff <= '0;
    end else if (i_inc && cnt_ff != LIMIT_W) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end
  assign o_done = i_run && (cnt_ff == LIMIT_W);
endmodule : lds_hold_timer
`default_nettype wire

// ### lds_wb_regs.sv
// Classic Wishbone slave holding the control register and showing status.
// Assumes a single-cycle master that holds its request until ack is seen.
`timescale 1ns/1ps
`default_nettype none
module lds_wb_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [7:0] i_adr,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] i_dat,
  output logic [31:0] o_dat,
  output logic o_ack,
  lds_regs_if.regs rif
);
  logic ack_ff;
  logic [1:0] ctrl_ff;
  logic [31:0] dat_ff;
  logic req;
  assign req = i_cyc && i_stb && !ack_ff;
  // Ack one cycle after the request, then drop so each request answers once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end
  // Control writes land on the request edge; only byte lane 0 carries fields.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= lds_pkg::CTRL_RESET;
    end else if (req && i_we && i_sel[0] && i_adr == lds_pkg::ADDR_CTRL) begin
      ctrl_ff <= i_dat[1:0];
    end
  end
  // Read data is captured with the ack; unmapped addresses read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_ff <= '0;
    end else if (req && !i_we) begin
      dat_ff <= '0;
      unique case (i_adr)
        lds_pkg::ADDR_CTRL: dat_ff[1:0] <= ctrl_ff;
        lds_pkg::ADDR_STATUS: begin
          dat_ff[3:0] <= rif.status_flags;
          dat_ff[lds_pkg::ST_PHASE_LSB +: 3] <= rif.phase;
        end
        lds_pkg::ADDR_CHAN: begin
          dat_ff[lds_pkg::CH_UNUSED_LSB +: lds_pkg::NUM_CH] <= rif.unused_mask;
          dat_ff[lds_pkg::CH_SHORT_LSB +: lds_pkg::NUM_CH] <= rif.short_mask;
        end
        default: dat_ff <= '0;
      endcase
    end
  end
  assign o_ack = ack_ff;
  assign o_dat = dat_ff;
  assign rif.ext_fault_en = ctrl_ff[lds_pkg::CTRL_EXT_FAULT_EN_BIT];
  assign rif.force_open_loop = ctrl_ff[lds_pkg::CTRL_FORCE_OPEN_LOOP_BIT];
endmodule : lds_wb_regs
`default_nettype wire

// ### lds_sequencer.sv
// Startup and fault sequencer for a six-channel boost LED driver.
// Assumes every comparator and pin input is asynchronous and is synchronised here.
// Functional notes
// RL1: Leave off only while enable is high and supply is above lockout.
// RL2: After power-up, boost and sinks run only while dimming input is high.
// RL3: Check output, LED, frequency-set and current-set faults before switching.
// RL4: Enable low longer than 16 ms shuts down; shorter lows are ignored.
// RL5: Host toggles dimming; sinks follow it while enable stays high.
// RL6: LED detection starts only with dimming high and disconnect drive on.
// RL7: After LED pins pass 120 mV, wait about 1.5 ms then classify.
// RL8: Below 120 mV short, near 230 mV unused, above 340 mV in use.
// RL9: Unused channels stay disabled and leave the feedback selection.
// RL10: Any shorted LED pin withholds soft-start and output ramp.
// RL11: Short faults pull fault low, detection retries, then continues.
// RL12: Fault output releases when detection completes without fault.
// RL13: Output below undervoltage after switch enable withholds soft-start.
// RL14: Output undervoltage shuts down at once into a latched-off state; only checked at gate-on in ST_WAKE and in ST_SOFT and ST_RUN.
// RL15: Latch clears on supply lockout or enable low over 16 ms.
// RL16: Dimming low over 16 ms with enable high clears latch, clock kept.
// RL17: Soft-start ends on all in regulation, 93% overvoltage, or timeout.
// RL18: Soft-start begins after detection and lasts about 16 ms at most.
// RL19: After wake, clock output runs and disconnect drive ramps on.
// RL20: Drive on enables current-set reference, then waits for dimming high.
// RL21: Too-short dimming pulses select open loop, otherwise closed loop.
// RL22: External fault low for 8 switching cycles turns LEDs off.
// RL23: Any shutdown returns to the start and repeats all power-up checks.
// RL24: Fault output is open-drain active low, released for a pull-up.
`timescale 1ns/1ps
`default_nettype none
module lds_sequencer #(
  parameter int EN_OFF_CYC = lds_pkg::EN_OFF_CYC,
  parameter int DETECT_CYC = lds_pkg::DETECT_CYC,
  parameter int SS_CYC = lds_pkg::SS_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // Host pins.
  input wire logic I_ENABLE,
  input wire logic I_DIM,
  // Analog comparator results.
  input wire logic I_SUPPLY_OK,
  input wire logic I_GATE_ON,
  input wire logic I_OUT_ABOVE_UV,
  input wire logic I_OV93,
  input wire logic I_FREQUENCY_SET_PIN_FAULT,
  input wire logic I_CURRENT_SET_PIN_FAULT,
  input wire logic I_DIM_TOO_SHORT,
  input wire logic [lds_pkg::NUM_CH-1:0] I_LED_ABOVE_LOW,
  input wire logic [lds_pkg::NUM_CH-1:0] I_LED_ABOVE_HIGH,
  input wire logic [lds_pkg::NUM_CH-1:0] I_LED_IN_REG,
  input wire logic I_SW_CLK,
  // Open-drain fault pin.
  input wire logic I_FAULT_N_I,
  output logic O_FAULT_N_O,
  output logic O_FAULT_N_OE,
  // Power stage controls.
  output logic O_CLOCK_OUTPUT_EN,
  output logic O_GATE_EN,
  output logic O_CURRENT_SET_PIN_EN,
  output logic O_BOOST_EN,
  output logic O_SOFT_START,
  output logic O_OPEN_LOOP,
  output logic [lds_pkg::NUM_CH-1:0] O_SINK_EN,
  output logic [lds_pkg::NUM_CH-1:0] O_FB_SEL,
  // Wishbone slave.
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK
);
  localparam int N = lds_pkg::NUM_CH;
  localparam int SW = 11 + 3 * N;
  // Synchronisers reset to idle pin levels, so the fault wire does not look pulled low.
  localparam logic [SW-1:0] SYNC_IDLE = {{9{1'b0}}, 1'b1, {(3 * N + 1){1'b0}}};

  lds_regs_if rif ();

  lds_pkg::lds_state_t state_ff;
  lds_pkg::lds_state_t nxt_state;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic sw_prev_ff;
  logic en_s, dim_s, sup_s, gate_s, uv_ok_s, ov93_s, frequency_set_pin_s, current_set_pin_s, short_pulse_s;
  logic fault_in_s, sw_s;
  logic [N-1:0] above_low_s, above_high_s, in_reg_s;
  logic sw_tick;
  logic en_low_done, dim_low_done, detect_done, ss_done, ext_low_done;
  logic [N-1:0] unused_ff, short_ff;
  logic fault_ff, ext_off_ff, open_loop_ff, latched;
  logic pin_fault, ss_exit;
  logic [N-1:0] active_ch;
  logic [N-1:0] sink_ff, fb_ff;
  logic boost_ff, ss_ff, clk_ff, gate_ff, current_set_pin_ff;
  logic [2:0] phase;

  // Two-stage synchronisers; only the second stage is looked at by logic.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end else begin
      sync1_ff <= {I_ENABLE, I_DIM, I_SUPPLY_OK, I_GATE_ON, I_OUT_ABOVE_UV, I_OV93,
                   I_FREQUENCY_SET_PIN_FAULT, I_CURRENT_SET_PIN_FAULT, I_DIM_TOO_SHORT, I_FAULT_N_I,
                   I_LED_ABOVE_LOW, I_LED_ABOVE_HIGH, I_LED_IN_REG, I_SW_CLK};
      sync2_ff <= sync1_ff;
    end
  end
  assign {en_s, dim_s, sup_s, gate_s, uv_ok_s, ov93_s, frequency_set_pin_s, current_set_pin_s, short_pulse_s,
          fault_in_s, above_low_s, above_high_s, in_reg_s, sw_s} = sync2_ff;

  // The switching clock is far slower than the reference, so its rising edge
  // can be found from the synchronised copy without missing a cycle.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sw_prev_ff <= 1'b0;
    end else begin
      sw_prev_ff <= sw_s;
    end
  end
  assign sw_tick = sw_s && !sw_prev_ff;

  // Long enable-low counts to shutdown; brief lows restart the count. [RL4]
  lds_hold_timer #(.W(lds_pkg::TMR_W), .LIMIT(EN_OFF_CYC)) u_en_low (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_run(!en_s),
    .i_inc(1'b1),
    .o_done(en_low_done)
  );

  // Dimming held low with enable high, only counted while latched off. [RL16]
  lds_hold_timer #(.W(lds_pkg::TMR_W), .LIMIT(EN_OFF_CYC)) u_dim_low (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_run(latched && en_s && !dim_s),
    .i_inc(1'b1),
    .o_done(dim_low_done)
  );

  // Settling wait once every pin has passed the low threshold. [RL7]
  lds_hold_timer #(.W(lds_pkg::TMR_W), .LIMIT(DETECT_CYC)) u_detect (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_run(state_ff == lds_pkg::ST_DETECT && !pin_fault),
    .i_inc(1'b1),
    .o_done(detect_done)
  );

  // Soft-start ramp time limit. [RL18]
  lds_hold_timer #(.W(lds_pkg::TMR_W), .LIMIT(SS_CYC)) u_soft (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_run(state_ff == lds_pkg::ST_SOFT),
    .i_inc(1'b1),
    .o_done(ss_done)
  );

  // External fault deglitch counts switching cycles with no internal fault. [RL22]
  lds_hold_timer #(.W(4), .LIMIT(lds_pkg::EXT_FAULT_SW_CYC)) u_ext (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_run(!fault_in_s && !fault_ff && rif.ext_fault_en),
    .i_inc(sw_tick),
    .o_done(ext_low_done)
  );

  // A pin still below the low threshold, or a set pin fault, blocks detection.
  assign pin_fault = !(&above_low_s) || frequency_set_pin_s || current_set_pin_s; // [RL3] [RL10]
  assign latched = state_ff == lds_pkg::ST_LATCHED;
  assign active_ch = ~unused_ff;
  assign ss_exit = (&(in_reg_s | unused_ff)) || ov93_s || ss_done; // [RL17]

  // Next phase. Shutdown conditions take priority over everything else and
  // always fall back to the off state so the checks repeat on next wake.
  always_comb begin
    nxt_state = state_ff;
    if (!sup_s || en_low_done) begin
      nxt_state = lds_pkg::ST_OFF; // [RL4] [RL15] [RL23]
    end else begin
      unique case (state_ff)
        lds_pkg::ST_OFF: begin
          if (en_s) begin
            nxt_state = lds_pkg::ST_WAKE; // [RL1]
          end
        end
        lds_pkg::ST_WAKE: begin
          if (gate_s) begin
            // The output must already sit above the undervoltage level here.
            nxt_state = uv_ok_s ? lds_pkg::ST_WAIT_DIM : lds_pkg::ST_LATCHED; // [RL13] [RL14]
          end
        end
        lds_pkg::ST_WAIT_DIM: begin
          if (dim_s && gate_s) begin
            nxt_state = lds_pkg::ST_DETECT; // [RL6] [RL20]
          end
        end
        lds_pkg::ST_DETECT: begin
          if (detect_done) begin
            nxt_state = lds_pkg::ST_SOFT; // [RL18]
          end
        end
        lds_pkg::ST_SOFT: begin
          if (!uv_ok_s) begin
            nxt_state = lds_pkg::ST_LATCHED; // [RL14]
          end else if (ss_exit) begin
            nxt_state = lds_pkg::ST_RUN; // [RL17]
          end
        end
        lds_pkg::ST_RUN: begin
          if (!uv_ok_s) begin
            nxt_state = lds_pkg::ST_LATCHED; // [RL14]
          end
        end
        lds_pkg::ST_LATCHED: begin
          // Clearing by dimming keeps the clock output running. [RL16]
          if (dim_low_done) begin
            nxt_state = lds_pkg::ST_WAKE; // [RL23]
          end
        end
      endcase
    end
  end

  // Phase register.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_ff <= lds_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The short mask follows the pins on every detection cycle and the unused mask is taken once at its end;
  // both are held for the run, and a fresh wake clears them so a rewired board is seen again.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      unused_ff <= '0;
      short_ff <= '0;
    end else if (state_ff == lds_pkg::ST_WAKE) begin
      unused_ff <= '0;
      short_ff <= '0;
    end else if (state_ff == lds_pkg::ST_DETECT) begin
      short_ff <= ~above_low_s; // [RL8]
      if (detect_done) begin
        unused_ff <= above_low_s & ~above_high_s; // [RL8] [RL9]
      end
    end
  end

  // Fault pin: pulled low on pin faults while detection retries, released
  // once detection completes cleanly, held low while latched off.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fault_ff <= 1'b0;
    end else if (nxt_state == lds_pkg::ST_OFF) begin
      fault_ff <= 1'b0;
    end else if (nxt_state == lds_pkg::ST_LATCHED) begin
      fault_ff <= 1'b1; // [RL14]
    end else if (state_ff == lds_pkg::ST_DETECT) begin
      if (pin_fault) begin
        fault_ff <= 1'b1; // [RL11]
      end else if (detect_done) begin
        fault_ff <= 1'b0; // [RL12]
      end
    end else if (state_ff == lds_pkg::ST_WAKE) begin
      fault_ff <= 1'b0;
    end
  end

  // External fault turns LEDs off until the pin is released again.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ext_off_ff <= 1'b0;
    end else if (fault_in_s || fault_ff) begin
      ext_off_ff <= 1'b0;
    end else if (ext_low_done) begin
      ext_off_ff <= 1'b1; // [RL22]
    end
  end

  // Regulation mode follows the dimming pulse width detector.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      open_loop_ff <= 1'b0;
    end else begin
      open_loop_ff <= short_pulse_s || rif.force_open_loop; // [RL21]
    end
  end

  // Power stage outputs. The clock and disconnect drive come up at wake even
  // with dimming low; boost and sinks follow dimming only after detection.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      clk_ff <= 1'b0;
      gate_ff <= 1'b0;
      current_set_pin_ff <= 1'b0;
      boost_ff <= 1'b0;
      ss_ff <= 1'b0;
      sink_ff <= '0;
      fb_ff <= '0;
    end else begin
      clk_ff <= nxt_state != lds_pkg::ST_OFF; // [RL19] [RL16]
      gate_ff <= nxt_state != lds_pkg::ST_OFF && nxt_state != lds_pkg::ST_LATCHED; // [RL19]
      current_set_pin_ff <= nxt_state == lds_pkg::ST_WAIT_DIM || nxt_state == lds_pkg::ST_DETECT ||
                 nxt_state == lds_pkg::ST_SOFT || nxt_state == lds_pkg::ST_RUN; // [RL20]
      ss_ff <= nxt_state == lds_pkg::ST_SOFT;
      if (nxt_state == lds_pkg::ST_SOFT || nxt_state == lds_pkg::ST_RUN) begin
        boost_ff <= dim_s && !ext_off_ff; // [RL2] [RL5]
        sink_ff <= (dim_s && !ext_off_ff) ? active_ch : '0; // [RL2] [RL5] [RL9]
        fb_ff <= active_ch; // [RL9]
      end else begin
        boost_ff <= 1'b0; // [RL3] [RL10]
        sink_ff <= '0;
        fb_ff <= '0;
      end
    end
  end

  // Phase code for software.
  always_comb begin
    unique case (state_ff)
      lds_pkg::ST_OFF: phase = lds_pkg::PH_OFF;
      lds_pkg::ST_WAKE: phase = lds_pkg::PH_WAKE;
      lds_pkg::ST_WAIT_DIM: phase = lds_pkg::PH_WAIT_DIM;
      lds_pkg::ST_DETECT: phase = lds_pkg::PH_DETECT;
      lds_pkg::ST_SOFT: phase = lds_pkg::PH_SOFT;
      lds_pkg::ST_RUN: phase = lds_pkg::PH_RUN;
      lds_pkg::ST_LATCHED: phase = lds_pkg::PH_LATCHED;
    endcase
  end

  assign rif.status_flags = {open_loop_ff, ext_off_ff, latched, fault_ff};
  assign rif.phase = phase;
  assign rif.unused_mask = unused_ff;
  assign rif.short_mask = short_ff;

  lds_wb_regs u_regs (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_cyc(I_WB_CYC),
    .i_stb(I_WB_STB),
    .i_we(I_WB_WE),
    .i_adr(I_WB_ADR),
    .i_sel(I_WB_SEL),
    .i_dat(I_WB_DAT),
    .o_dat(O_WB_DAT),
    .o_ack(O_WB_ACK),
    .rif(rif.regs)
  );

  // Open-drain fault pin: enable means pulling low, data is always zero. [RL24]
  assign O_FAULT_N_O = 1'b0;
  assign O_FAULT_N_OE = fault_ff; // [RL24]
  assign O_CLOCK_OUTPUT_EN = clk_ff;
  assign O_GATE_EN = gate_ff;
  assign O_CURRENT_SET_PIN_EN = current_set_pin_ff;
  assign O_BOOST_EN = boost_ff;
  assign O_SOFT_START = ss_ff;
  assign O_OPEN_LOOP = open_loop_ff;
  assign O_SINK_EN = sink_ff;
  assign O_FB_SEL = fb_ff;
endmodule : lds_sequencer
`default_nettype wire

// ### lds_checker.sv
// Concurrent checks on the sequencer pins, bound to every instance.
// Assumes stimulus holds each comparator input for several cycles.
`timescale 1ns/1ps
`default_nettype none
module lds_checker #(
  parameter int EN_OFF_CYC = 40,
  parameter int SS_CYC = 60
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_ENABLE,
  input wire logic I_DIM,
  input wire logic I_SUPPLY_OK,
  input wire logic I_GATE_ON,
  input wire logic I_OUT_ABOVE_UV,
  input wire logic O_FAULT_N_O,
  input wire logic O_FAULT_N_OE,
  input wire logic O_CLOCK_OUTPUT_EN,
  input wire logic O_GATE_EN,
  input wire logic O_CURRENT_SET_PIN_EN,
  input wire logic O_BOOST_EN,
  input wire logic O_SOFT_START
);
  int en_lo_ff;
  int sup_lo_ff;
  int ss_ff;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  // Run lengths; the pins are raw, so the design's own counts lag these.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      en_lo_ff <= 0;
      sup_lo_ff <= 0;
      ss_ff <= 0;
    end else begin
      en_lo_ff <= I_ENABLE ? 0 : en_lo_ff + 1;
      sup_lo_ff <= I_SUPPLY_OK ? 0 : sup_lo_ff + 1;
      ss_ff <= O_SOFT_START ? ss_ff + 1 : 0;
    end
  end
  a_fault_od: assert property (O_FAULT_N_O == 1'b0)
    else $error("fault pin data is not low");
  a_wake_cond: assert property
    ($rose(O_CLOCK_OUTPUT_EN) |-> $past(I_ENABLE, 2) && $past(I_SUPPLY_OK, 2))
    else $error("woke without enable and supply");
  a_dim_gate: assert property ($fell(I_DIM) |-> ##[0:6] !O_BOOST_EN)
    else $error("boost kept on after dim fell");
  a_soft_clean: assert property (O_SOFT_START |-> !O_FAULT_N_OE)
    else $error("soft-start while fault driven");
  a_en_shut: assert property (en_lo_ff == EN_OFF_CYC + 6 |-> !O_CLOCK_OUTPUT_EN)
    else $error("no shutdown after long enable low");
  a_no_early_off: assert property
    ($fell(O_CLOCK_OUTPUT_EN) |-> en_lo_ff >= EN_OFF_CYC || sup_lo_ff > 0)
    else $error("shutdown without cause");
  a_uv_latch: assert property
    ((O_CLOCK_OUTPUT_EN && I_GATE_ON && !I_OUT_ABOVE_UV)[*5] |-> O_FAULT_N_OE && !O_SOFT_START)
    else $error("output undervoltage not latched");
  a_current_set_pin_gate: assert property ($rose(O_CURRENT_SET_PIN_EN) |-> $past(I_GATE_ON, 2))
    else $error("reference enabled before gate on");
  a_boost_chain: assert property
    (O_BOOST_EN |-> O_CLOCK_OUTPUT_EN && O_GATE_EN && O_CURRENT_SET_PIN_EN)
    else $error("boost on without wake chain");
  a_soft_bound: assert property (ss_ff <= SS_CYC + 4)
    else $error("soft-start outlived its timer");
endmodule : lds_checker
bind lds_sequencer lds_checker #(.EN_OFF_CYC(EN_OFF_CYC), .SS_CYC(SS_CYC)) i_chk (.*);
`default_nettype wire

// ### lds_host.sv
// Host controller model driving the enable and dimming levels.
// Assumes the bench calls its task from one process only.
`timescale 1ns/1ps
`default_nettype none
module lds_host (
  input wire logic i_clk,
  output logic o_en,
  output logic o_dim
);
  // Both levels start low so the device stays off until asked.
  initial begin
    o_en = 1'b0;
    o_dim = 1'b0;
  end
  // Levels change just after an edge and stand until the next call.
  task automatic drive(input logic en, input logic dim);
    @(posedge i_clk);
    o_en <= en;
    o_dim <= dim;
  endtask : drive
endmodule : lds_host
`default_nettype wire

// ### tb.sv
// Self-checking bench for the startup sequencer with short counts.
// Assumes the host model and checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int EOC = 40;
  localparam int DC = 30;
  localparam int SC = 60;
  logic clk = 0, rstn = 0, sup = 0, gon = 0, uv = 1, ov = 0, fs = 0, is = 0, dts = 0;
  logic swc = 0, ext_lo = 0, cyc = 0, stb = 0, we = 0, en, dim, fo, foe, ack;
  logic cken, gen, isen, bst, ss, ol;
  logic [5:0] alo = 0, ahi = 0, inreg = 0, snk, fb;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rdat, q;
  logic [16:0] lf = 17'd86170;
  int fails = 0, n_tests = 0, k;
  // The fault wire has a pull-up; either party may pull it low.
  wire fw = !((foe && !fo) || ext_lo);
  always #2 clk = ~clk;
  lds_host i_host (.i_clk(clk), .o_en(en), .o_dim(dim));
  lds_sequencer #(.EN_OFF_CYC(EOC), .DETECT_CYC(DC), .SS_CYC(SC)) i_dut (
    .I_REF_CLK(clk), .I_RESETN(rstn), .I_ENABLE(en), .I_DIM(dim), .I_SUPPLY_OK(sup),
    .I_GATE_ON(gon), .I_OUT_ABOVE_UV(uv), .I_OV93(ov), .I_FREQUENCY_SET_PIN_FAULT(fs),
    .I_CURRENT_SET_PIN_FAULT(is), .I_DIM_TOO_SHORT(dts), .I_LED_ABOVE_LOW(alo),
    .I_LED_ABOVE_HIGH(ahi), .I_LED_IN_REG(inreg), .I_SW_CLK(swc), .I_FAULT_N_I(fw),
    .O_FAULT_N_O(fo), .O_FAULT_N_OE(foe), .O_CLOCK_OUTPUT_EN(cken), .O_GATE_EN(gen),
    .O_CURRENT_SET_PIN_EN(isen), .O_BOOST_EN(bst), .O_SOFT_START(ss), .O_OPEN_LOOP(ol),
    .O_SINK_EN(snk), .O_FB_SEL(fb), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack));
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nx
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    for (j = 0; j < 20 && ack !== 1'b1; j++) @(posedge clk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    chk(j < 20, 1);
    if (j >= 20) end_of_test;
  endtask : wb
  task automatic sw(input int n);
    repeat (n) begin
      swc <= 1'b1;
      cy(3);
      swc <= 1'b0;
      cy(3);
    end
  endtask : sw
  task automatic end_of_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // A hang anywhere is cut short here and counted as a mismatch.
  initial begin
    cy(20000);
    fails++;
    end_of_test;
  end
  // Main sequence; expectations come from the short counts set above.
  initial begin
    cy(2);
    rstn <= 1'b1;
    chk({cken, gen, isen, bst, ss, foe, snk}, 0);
    wb(0, lds_pkg::ADDR_CTRL, 0);
    chk(q, lds_pkg::CTRL_RESET);
    wb(0, 8'h0C, 0);
    chk(q, 0);
    lf = nx(lf);
    wb(1, lds_pkg::ADDR_CTRL, lf);
    wb(0, lds_pkg::ADDR_CTRL, 0);
    chk(q, lf & 3);
    wb(1, lds_pkg::ADDR_CTRL, 32'h1);
    i_host.drive(1, 0);
    cy(10);
    chk(cken, 0);
    sup <= 1'b1;
    for (k = 0; k < 20 && cken !== 1'b1; k++) cy(1);
    chk({cken, gen, isen}, 3'h6);
    gon <= 1'b1;
    for (k = 0; k < 20 && isen !== 1'b1; k++) cy(1);
    chk(isen, 1);
    cy(10);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk({q[10:8], bst}, {lds_pkg::PH_WAIT_DIM, 1'b0});
    alo <= 6'h3E;
    ahi <= 6'h3B;
    i_host.drive(1, 1);
    cy(DC + 20);
    chk({foe, ss}, 2'h2);
    wb(0, lds_pkg::ADDR_CHAN, 0);
    chk(q[13:8], 6'h01);
    alo <= 6'h3F;
    fs <= 1'b1;
    cy(10);
    chk({foe, ss}, 2'h2);
    fs <= 1'b0;
    for (k = 0; k < DC + 30 && ss !== 1'b1; k++) cy(1);
    chk(k >= DC, 1);
    chk({ss, foe}, 2'h2);
    wb(0, lds_pkg::ADDR_CHAN, 0);
    chk(q[5:0], 6'h04);
    chk({snk, fb[2]}, {6'h3B, 1'b0});
    inreg <= 6'h3B;
    for (k = 0; k < 20 && ss !== 1'b0; k++) cy(1);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk(q[10:8], lds_pkg::PH_RUN);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      i_host.drive(1, lf[0]);
      cy(10);
      chk({snk, bst}, lf[0] ? 7'h77 : 7'h00);
    end
    i_host.drive(1, 1);
    dts <= 1'b1;
    cy(8);
    chk(ol, 1);
    dts <= 1'b0;
    ext_lo <= 1'b1;
    sw(4);
    chk(bst, 1);
    sw(5);
    chk({bst, snk}, 0);
    ext_lo <= 1'b0;
    cy(10);
    chk(bst, 1);
    i_host.drive(0, 1);
    cy(EOC / 2);
    i_host.drive(1, 1);
    cy(10);
    chk(cken, 1);
    i_host.drive(0, 0);
    cy(EOC + 10);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk({cken, q[10:8]}, {1'b0, lds_pkg::PH_OFF});
    uv <= 1'b0;
    i_host.drive(1, 0);
    cy(15);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk({foe, q[10:8]}, {1'b1, lds_pkg::PH_LATCHED});
    uv <= 1'b1;
    cy(EOC + 15);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk({cken, q[10:8]}, {1'b1, lds_pkg::PH_WAIT_DIM});
    sup <= 1'b0;
    cy(10);
    wb(0, lds_pkg::ADDR_STATUS, 0);
    chk({cken, gen, q[10:8]}, {2'b00, lds_pkg::PH_OFF});
    end_of_test;
  end
endmodule : tb
`default_nettype wire
